// ==== rtl/rx_lane_status_defines.svh ====
`ifndef RX_LANE_STATUS_DEFINES_SVH
`define RX_LANE_STATUS_DEFINES_SVH

// register offsets (byte addresses, one word each)
`define RX_LANE_FIFO_FLAGS_OFFSET 8'h00
`define RX_LANE_ALIGN_CALIB_STATE_OFFSET 8'h04
`define RX_LANE_CDR_LOCK_STATE_OFFSET 8'h08
`define RX_LANE_IRQ_STATUS_OFFSET 8'h0c
`define RX_LANE_IRQ_MASK_OFFSET 8'h10

// field positions
`define EMPTY_FIELD_LSB 16
`define FULL_FIELD_LSB 0
`define ALIGNED_FIELD_LSB 16
`define CALIB_FIELD_LSB 0
`define LOCKED_FIELD_LSB 0

// interrupt status bit positions
`define IRQ_FULL_BIT 0
`define IRQ_ALIGN_LOSS_BIT 1
`define IRQ_LOCK_LOSS_BIT 2

// reset values
`define STATUS_RESET_VALUE 32'h0000_0000
`define IRQ_RESET_VALUE 3'h0

`endif

// ==== rtl/rx_lane_status_pkg.sv ====
package rx_lane_status_pkg;
  typedef logic [31:0] word_t;
  typedef logic [2:0] irq_bits_t;
endpackage

// ==== rtl/rx_lane_status_monitor.sv ====
// The implementer's own choices: the placing of the registers and strobed register access.
`include "rx_lane_status_defines.svh"

// Operation
// - word one bits 23:16 show per-lane phase fifo empty flags
// - word one bits 7:0 show per-lane phase fifo full flags
// - word two bits 23:16 show per-lane word alignment found
// - word two bits 7:0 show per-lane receive calibration running
// - word three bits 7:0 show per-lane recovery loop locked to data
// - words one to three read-only, all words reset zero, unused bits read zero
module rx_lane_status_monitor #(
  parameter int LANES = 8
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic irq,
  input wire logic [LANES-1:0] lane_phase_fifo_empty_flag,
  input wire logic [LANES-1:0] lane_phase_fifo_full_flag,
  input wire logic [LANES-1:0] lane_word_aligned_flag,
  input wire logic [LANES-1:0] lane_calibration_running,
  input wire logic [LANES-1:0] lane_recovery_data_locked
);

  localparam int SIG = 5 * LANES;

  typedef struct packed {
    logic [SIG-1:0] sync1;
    logic [SIG-1:0] sync2;
    logic [LANES-1:0] empty;
    logic [LANES-1:0] full;
    logic [LANES-1:0] aligned;
    logic [LANES-1:0] calib;
    logic [LANES-1:0] locked;
    rx_lane_status_pkg::irq_bits_t irq_status;
    rx_lane_status_pkg::irq_bits_t irq_mask;
    rx_lane_status_pkg::word_t rdata;
    logic irq;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic [SIG-1:0] raw;
  rx_lane_status_pkg::word_t word1;
  rx_lane_status_pkg::word_t word2;
  rx_lane_status_pkg::word_t word3;
  rx_lane_status_pkg::irq_bits_t events;

  assign raw = {lane_phase_fifo_empty_flag, lane_phase_fifo_full_flag,
                lane_word_aligned_flag, lane_calibration_running,
                lane_recovery_data_locked};

  always_comb begin
    word1 = `STATUS_RESET_VALUE;
    word2 = `STATUS_RESET_VALUE;
    word3 = `STATUS_RESET_VALUE;
    word1[`EMPTY_FIELD_LSB +: LANES] = state_reg.empty;
    word1[`FULL_FIELD_LSB +: LANES] = state_reg.full;
    word2[`ALIGNED_FIELD_LSB +: LANES] = state_reg.aligned;
    word2[`CALIB_FIELD_LSB +: LANES] = state_reg.calib;
    word3[`LOCKED_FIELD_LSB +: LANES] = state_reg.locked;
  end

  always_comb begin
    state_next = state_reg;
    // three-stage sampling (sync1, sync2, then the field registers); lane signals come from other clocks
    state_next.sync1 = raw;
    state_next.sync2 = state_reg.sync1;
    {state_next.empty, state_next.full, state_next.aligned,
     state_next.calib, state_next.locked} = state_reg.sync2;
    // events: a lane fifo newly full, alignment lost, data lock lost
    events = '0;
    events[`IRQ_FULL_BIT] = |(state_next.full & ~state_reg.full);
    events[`IRQ_ALIGN_LOSS_BIT] =
      |(~state_next.aligned & state_reg.aligned);
    events[`IRQ_LOCK_LOSS_BIT] = |(~state_next.locked & state_reg.locked);
    if (reg_write) begin
      unique case (reg_addr)
        `RX_LANE_IRQ_STATUS_OFFSET: begin
          state_next.irq_status = state_reg.irq_status & ~reg_wdata[2:0];
        end
        `RX_LANE_IRQ_MASK_OFFSET: begin
          state_next.irq_mask = reg_wdata[2:0];
        end
        default: begin
        end
      endcase
    end
    // a new event wins over a same-cycle clear
    state_next.irq_status = state_next.irq_status | events;
    state_next.irq = |(state_next.irq_status & state_next.irq_mask);
    // read-only words, unmapped and unused bits read zero
    state_next.rdata = `STATUS_RESET_VALUE;
    if (reg_read) begin
      unique case (reg_addr)
        `RX_LANE_FIFO_FLAGS_OFFSET: state_next.rdata = word1;
        `RX_LANE_ALIGN_CALIB_STATE_OFFSET: state_next.rdata = word2;
        `RX_LANE_CDR_LOCK_STATE_OFFSET: state_next.rdata = word3;
        `RX_LANE_IRQ_STATUS_OFFSET: begin
          state_next.rdata[2:0] = state_reg.irq_status;
        end
        `RX_LANE_IRQ_MASK_OFFSET: begin
          state_next.rdata[2:0] = state_reg.irq_mask;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata = state_reg.rdata;
  assign irq = state_reg.irq;

endmodule

// ==== bench/rx_lane_status_sva.sv ====
module rx_lane_status_sva (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  chk_rdata_idle: assert property (
    !reg_read |=> reg_rdata == 32'h0) else $error("stray read data");
  chk_pad_low: assert property (
    reg_read && reg_addr[7:3] == 5'h0 |=>
    reg_rdata[31:24] == 8'h0 && reg_rdata[15:8] == 8'h0)
    else $error("pad bits set");
  chk_pad_cdr: assert property (
    reg_read && reg_addr == 8'h08 |=> reg_rdata[31:8] == 24'h0)
    else $error("lock word pad set");
  chk_reset_clear: assert property (
    disable iff (1'b0) reset |=> reg_rdata == 32'h0 && !irq)
    else $error("outputs not cleared by reset");
  chk_unmapped_zero: assert property (
    reg_read && reg_addr > 8'h10 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_irq_pad: assert property (
    reg_read && (reg_addr == 8'h0c || reg_addr == 8'h10) |=>
    reg_rdata[31:3] == 29'h0)
    else $error("interrupt word pad set");
  chk_mask_off_irq: assert property (
    reg_write && reg_addr == 8'h10 && reg_wdata[2:0] == 3'h0 |=> !irq)
    else $error("masked interrupt still high");
endmodule
bind rx_lane_status_monitor rx_lane_status_sva i_sva(.clk_sys(clk_sys),
  .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .irq(irq));

// ==== bench/rx_lane_status_monitor_tb.sv ====
module rx_lane_status_monitor_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'h0, reset = 1'h1, reg_write = 1'h0, reg_read = 1'h0;
  logic rd_d = 1'h0, irq;
  logic [7:0] reg_addr = 8'h0, em = 8'h0, fu = 8'h0, al = 8'h0;
  logic [7:0] ca = 8'h0, lk = 8'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, s = 32'hb444, v, w;
  logic [2:0] ex = 3'h0;
  logic [31:0] q[$];
  int n_errors = 0, check_count = 0;
  always #4 clk_sys = ~clk_sys;
  rx_lane_status_monitor i_dut(.clk_sys(clk_sys), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq),
    .lane_phase_fifo_empty_flag(em), .lane_phase_fifo_full_flag(fu),
    .lane_word_aligned_flag(al), .lane_calibration_running(ca),
    .lane_recovery_data_locked(lk));
  function logic [31:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task ck(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'h1;
    @(posedge clk_sys);
    reg_write <= 1'h0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'h1;
    @(posedge clk_sys);
    reg_read <= 1'h0;
  endtask
  // inputs settle well past the synchroniser before any read
  task lanes();
    v = xs();
    w = xs();
    @(posedge clk_sys);
    ex |= {|(lk & ~w[15:8]), |(al & ~w[7:0]), |(~fu & v[15:8])};
    {ca, fu, em} <= v[23:0];
    {lk, al} <= w[15:0];
    repeat (5) @(posedge clk_sys);
  endtask
  task wrap_up();
    if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    rd_d <= reg_read;
    if (rd_d) ck(reg_rdata, q.pop_front());
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    reset <= 1'h0;
    rd(8'h00, 32'h0);
    repeat (3) begin
      lanes();
      wr(8'h00, xs());
      rd(8'h00, {8'h0, em, 8'h0, fu});
      wr(8'h04, xs());
      rd(8'h04, {8'h0, al, 8'h0, ca});
      wr(8'h08, xs());
      rd(8'h08, {24'h0, lk});
    end
    rd(8'h20, 32'h0);
    rd(8'h0c, {29'h0, ex});
    #1 ck({31'h0, irq}, 32'h0);
    wr(8'h10, 32'h7);
    rd(8'h10, 32'h7);
    #1 ck({31'h0, irq}, {31'h0, |ex});
    wr(8'h10, 32'h0);
    #1 ck({31'h0, irq}, 32'h0);
    wr(8'h10, 32'h7);
    wr(8'h0c, 32'h7);
    #1 ck({31'h0, irq}, 32'h0);
    rd(8'h0c, 32'h0);
    repeat (3) @(posedge clk_sys);
    wrap_up();
  end
endmodule
